/* src/dioflx_top.sv */
// Purpose: function assignment and switch evaluation of three multipurpose lines
// Assumes: one clock mclk, synchronous active-low reset, 16-bit parameter port
// Notes: rst_b stands for power-on; function selectors load into the active copy only then
`timescale 1ns/1ps
`include "dioflx_map.svh"
module dioflx_top
    import dioflx_pkg::*;
(
    input wire logic mclk,
    input wire logic rst_b,
    input wire logic [11:0] parAddr,
    input wire logic [15:0] parWdata,
    input wire logic parWrite,
    input wire logic parRead,
    output logic [15:0] parRdata,
    output logic parAck,
    output logic parErr,
    input wire logic powerStageOn,
    input wire logic localMode,
    input wire logic cyclicSyncMode,
    input wire logic refMoveActive,
    input wire logic noFault,
    input wire logic driveReady,
    input wire logic [2:0] outFreeLevel,
    input wire logic [2:0] linePinIn,
    output logic [2:0] linePinOut,
    output logic [2:0] linePinOe,
    input wire logic posLimitPin,
    input wire logic limitErrClear,
    output logic faultResetReq,
    output logic enableReq,
    output logic negLimitHit,
    output logic posLimitHit,
    output logic refSwitchHit,
    output logic limitErr
);
    dioflx_word_t limRelease_reg;
    dioflx_word_t refPol_reg;
    dioflx_word_t negPol_reg;
    dioflx_word_t posPol_reg;
    dioflx_word_t func_reg [3];
    dioflx_word_t funcAct_reg [3];
    dioflx_word_t limReleaseAct_reg;
    dioflx_word_t refPolAct_reg;
    dioflx_word_t negPolAct_reg;
    dioflx_word_t posPolAct_reg;
    logic [2:0] pinMeta;
    logic [2:0] pinSync;
    logic posMeta;
    logic posSync;
    logic powerPrev;
    logic [2:0] lineFr;
    logic [2:0] lineEn;
    logic [2:0] lineRef;
    logic [2:0] lineRefUsed;
    logic [2:0] lineNeg;
    logic [2:0] lineNegUsed;
    logic negLevel;
    logic refLevel;
    logic refUsed;
    logic negNext;
    logic posNext;
    logic refNext;
    logic powerRise;
    logic validWrite;
    logic codeOk;
    logic hitAtEnable;
    logic justEnabled_reg;
    logic suppress_reg;
    logic maskNow;

    // two stages for every pin; first stage feeds nothing else
    always_ff @(posedge mclk) begin
        if (!rst_b) begin
            pinMeta <= 3'h0;
            pinSync <= 3'h0;
            posMeta <= 1'b0;
            posSync <= 1'b0;
        end else begin
            pinMeta <= linePinIn;
            pinSync <= pinMeta;
            posMeta <= posLimitPin;
            posSync <= posMeta;
        end
    end

    always_ff @(posedge mclk) begin
        if (!rst_b) begin
            powerPrev <= 1'b0;
        end else begin
            powerPrev <= powerStageOn;
        end
    end
    assign powerRise = powerStageOn && !powerPrev;

    function automatic logic funcLegal(input logic [1:0] line, input dioflx_word_t code);
        logic ok;
        ok = 1'b0;
        unique case (code)
            `DIOFLX_FN_FREE, `DIOFLX_FN_FAULT_RESET, `DIOFLX_FN_ENABLE, `DIOFLX_FN_FOUR,
            `DIOFLX_FN_JOG_NEG, `DIOFLX_FN_JOG_FAST, `DIOFLX_FN_REF,
            `DIOFLX_FN_OUT_FREE, `DIOFLX_FN_OUT_NO_FAULT, `DIOFLX_FN_OUT_READY: ok = 1'b1;
            `DIOFLX_FN_LIM_NEG: ok = (line == 2'd0);
            `DIOFLX_FN_JOG_POS: ok = (line != 2'd0);
            default: ok = 1'b0;
        endcase
        return ok;
    endfunction : funcLegal

    // code check for the addressed parameter
    always_comb begin
        codeOk = 1'b0;
        unique case (parAddr)
            `DIOFLX_OFF_LIM_RELEASE: codeOk = parWdata <= `DIOFLX_REL_MODE2;
            `DIOFLX_OFF_REF_POL: codeOk = parWdata == `DIOFLX_POL_NC
                || parWdata == `DIOFLX_POL_NO;
            `DIOFLX_OFF_NEG_POL: codeOk = parWdata <= `DIOFLX_POL_NO;
            `DIOFLX_OFF_POS_POL: codeOk = parWdata <= `DIOFLX_POL_NO;
            `DIOFLX_OFF_LINE_TWO: codeOk = funcLegal(2'd0, parWdata);
            `DIOFLX_OFF_LINE_THREE: codeOk = funcLegal(2'd1, parWdata);
            `DIOFLX_OFF_LINE_FOUR: codeOk = funcLegal(2'd2, parWdata);
            default: codeOk = 1'b0;
        endcase
    end
    assign validWrite = parWrite && codeOk && !powerStageOn;

    always_ff @(posedge mclk) begin
        if (!rst_b) begin
            limRelease_reg <= `DIOFLX_RST_LIM_RELEASE;
            refPol_reg <= `DIOFLX_RST_POL;
            negPol_reg <= `DIOFLX_RST_POL;
            posPol_reg <= `DIOFLX_RST_POL;
            func_reg[0] <= `DIOFLX_RST_FUNC;
            func_reg[1] <= `DIOFLX_RST_FUNC;
            func_reg[2] <= `DIOFLX_RST_FUNC;
        end else if (validWrite) begin
            unique case (parAddr)
                `DIOFLX_OFF_LIM_RELEASE: limRelease_reg <= parWdata;
                `DIOFLX_OFF_REF_POL: refPol_reg <= parWdata;
                `DIOFLX_OFF_NEG_POL: negPol_reg <= parWdata;
                `DIOFLX_OFF_POS_POL: posPol_reg <= parWdata;
                `DIOFLX_OFF_LINE_TWO: func_reg[0] <= parWdata;
                `DIOFLX_OFF_LINE_THREE: func_reg[1] <= parWdata;
                `DIOFLX_OFF_LINE_FOUR: func_reg[2] <= parWdata;
                default: ;
            endcase
        end
    end

    // reset is the power-on event; stored values are not persistent here
    always_ff @(posedge mclk) begin
        if (!rst_b) begin
            funcAct_reg[0] <= `DIOFLX_RST_FUNC;
            funcAct_reg[1] <= `DIOFLX_RST_FUNC;
            funcAct_reg[2] <= `DIOFLX_RST_FUNC;
        end
    end

    always_ff @(posedge mclk) begin
        if (!rst_b) begin
            limReleaseAct_reg <= `DIOFLX_RST_LIM_RELEASE;
            refPolAct_reg <= `DIOFLX_RST_POL;
            negPolAct_reg <= `DIOFLX_RST_POL;
            posPolAct_reg <= `DIOFLX_RST_POL;
        end else if (powerRise) begin
            limReleaseAct_reg <= limRelease_reg;
            refPolAct_reg <= refPol_reg;
            negPolAct_reg <= negPol_reg;
            posPolAct_reg <= posPol_reg;
        end
    end

    always_ff @(posedge mclk) begin
        if (!rst_b) begin
            parRdata <= 16'h0000;
            parAck <= 1'b0;
            parErr <= 1'b0;
        end else begin
            parAck <= parWrite || parRead;
            parErr <= parWrite && !validWrite;
            parRdata <= 16'h0000;
            if (parRead) begin
                unique case (parAddr)
                    `DIOFLX_OFF_LIM_RELEASE: parRdata <= limRelease_reg;
                    `DIOFLX_OFF_REF_POL: parRdata <= refPol_reg;
                    `DIOFLX_OFF_NEG_POL: parRdata <= negPol_reg;
                    `DIOFLX_OFF_POS_POL: parRdata <= posPol_reg;
                    `DIOFLX_OFF_LINE_TWO: parRdata <= func_reg[0];
                    `DIOFLX_OFF_LINE_THREE: parRdata <= func_reg[1];
                    `DIOFLX_OFF_LINE_FOUR: parRdata <= func_reg[2];
                    default: parErr <= 1'b1;
                endcase
            end
        end
    end

    for (genvar i = 0; i < 3; i++) begin : gLine
        dioflx_line uLine (
            .mclk(mclk),
            .rst_b(rst_b),
            .activeFunc(funcAct_reg[i]),
            .pinSync(pinSync[i]),
            .localMode(localMode),
            .outFreeLevel(outFreeLevel[i]),
            .noFault(noFault),
            .driveReady(driveReady),
            .pinOut(linePinOut[i]),
            .pinOe(linePinOe[i]),
            .faultResetReq(lineFr[i]),
            .enableReq(lineEn[i]),
            .refLevel(lineRef[i]),
            .refUsed(lineRefUsed[i]),
            .limNegLevel(lineNeg[i]),
            .limNegUsed(lineNegUsed[i])
        );
    end

    assign negLevel = |(lineNeg & lineNegUsed);
    assign refLevel = |(lineRef & lineRefUsed);
    assign refUsed = |lineRefUsed;

    function automatic logic switchHit(input dioflx_word_t pol, input logic level);
        logic hit;
        hit = 1'b0;
        if (pol == `DIOFLX_POL_NC) begin
            hit = !level;
        end else if (pol == `DIOFLX_POL_NO) begin
            hit = level;
        end
        return hit;
    endfunction : switchHit

    always_comb begin
        negNext = |lineNegUsed && switchHit(negPolAct_reg, negLevel);
        posNext = switchHit(posPolAct_reg, posSync);
        refNext = refMoveActive && refUsed && switchHit(refPolAct_reg, refLevel);
    end

    always_ff @(posedge mclk) begin
        if (!rst_b) begin
            negLimitHit <= 1'b0;
            posLimitHit <= 1'b0;
            refSwitchHit <= 1'b0;
            faultResetReq <= 1'b0;
            enableReq <= 1'b0;
        end else begin
            negLimitHit <= negNext;
            posLimitHit <= posNext;
            refSwitchHit <= refNext;
            faultResetReq <= |lineFr;
            enableReq <= |lineEn;
        end
    end

    // first cycle after the enable edge: active copies hold the new settings by then
    always_ff @(posedge mclk) begin
        if (!rst_b) begin
            justEnabled_reg <= 1'b0;
        end else begin
            justEnabled_reg <= powerRise;
        end
    end

    // mode 2 in cyclic sync mode masks a switch already hit at enable until it is released
    assign hitAtEnable = justEnabled_reg && cyclicSyncMode && (negNext || posNext)
        && limReleaseAct_reg == `DIOFLX_REL_MODE2;
    assign maskNow = suppress_reg || hitAtEnable;

    always_ff @(posedge mclk) begin
        if (!rst_b) begin
            suppress_reg <= 1'b0;
        end else if (!powerStageOn || !(negNext || posNext)) begin
            suppress_reg <= 1'b0;
        end else if (hitAtEnable) begin
            suppress_reg <= 1'b1;
        end
    end

    // error sticks; set wins over clear; clear only allowed with release active
    // the enabling cycle is skipped since polarities there are still the old ones
    always_ff @(posedge mclk) begin
        if (!rst_b) begin
            limitErr <= 1'b0;
        end else if (powerStageOn && powerPrev && (negNext || posNext) && !maskNow) begin
            limitErr <= 1'b1;
        end else if (limitErrClear && cyclicSyncMode
            && limReleaseAct_reg != `DIOFLX_REL_OFF) begin
            limitErr <= 1'b0;
        end
    end
endmodule : dioflx_top

/* src/dioflx_map.svh */
// Purpose: offsets, field codes, reset values for the drive i/o function block
// Assumes: 16-bit parameter port, offsets are parameter addresses
// Notes: definitions only
`ifndef DIOFLX_MAP_SVH
`define DIOFLX_MAP_SVH

`define DIOFLX_OFF_LIM_RELEASE 12'h060c
`define DIOFLX_OFF_REF_POL 12'h061c
`define DIOFLX_OFF_NEG_POL 12'h061e
`define DIOFLX_OFF_POS_POL 12'h0620
`define DIOFLX_OFF_LINE_TWO 12'h0724
`define DIOFLX_OFF_LINE_THREE 12'h0726
`define DIOFLX_OFF_LINE_FOUR 12'h0728

`define DIOFLX_RST_LIM_RELEASE 16'h0000
`define DIOFLX_RST_POL 16'h0001
`define DIOFLX_RST_FUNC 16'h0001

`define DIOFLX_FN_FREE 16'h0001
`define DIOFLX_FN_FAULT_RESET 16'h0002
`define DIOFLX_FN_ENABLE 16'h0003
`define DIOFLX_FN_FOUR 16'h0004
`define DIOFLX_FN_JOG_POS 16'h0009
`define DIOFLX_FN_JOG_NEG 16'h000a
`define DIOFLX_FN_JOG_FAST 16'h000b
`define DIOFLX_FN_REF 16'h0014
`define DIOFLX_FN_LIM_NEG 16'h0016
`define DIOFLX_FN_OUT_FREE 16'h0065
`define DIOFLX_FN_OUT_NO_FAULT 16'h0066
`define DIOFLX_FN_OUT_READY 16'h0067

`define DIOFLX_POL_INACTIVE 16'h0000
`define DIOFLX_POL_NC 16'h0001
`define DIOFLX_POL_NO 16'h0002
`define DIOFLX_REL_OFF 16'h0000
`define DIOFLX_REL_MODE1 16'h0001
`define DIOFLX_REL_MODE2 16'h0002

`endif

/* src/dioflx_pkg.sv */
// Purpose: types for the drive i/o function block
// Assumes: nothing
// Notes: none
package dioflx_pkg;
    typedef enum logic [1:0] {
        DIOFLX_LINE_TWO,
        DIOFLX_LINE_THREE,
        DIOFLX_LINE_FOUR
    } dioflx_line_t;
    typedef logic [15:0] dioflx_word_t;
endpackage : dioflx_pkg

/* src/dioflx_line.sv */
// Purpose: one multipurpose i/o line, decodes its active function
// Assumes: pin already synchronised by caller
// Notes: one instance per line
`timescale 1ns/1ps
`include "dioflx_map.svh"
module dioflx_line
    import dioflx_pkg::*;
(
    input wire logic mclk,
    input wire logic rst_b,
    input wire logic [15:0] activeFunc,
    input wire logic pinSync,
    input wire logic localMode,
    input wire logic outFreeLevel,
    input wire logic noFault,
    input wire logic driveReady,
    output logic pinOut,
    output logic pinOe,
    output logic faultResetReq,
    output logic enableReq,
    output logic refLevel,
    output logic refUsed,
    output logic limNegLevel,
    output logic limNegUsed
);
    logic isOut;
    logic outVal;

    always_comb begin
        isOut = 1'b1;
        outVal = 1'b0;
        unique case (activeFunc)
            `DIOFLX_FN_OUT_FREE: outVal = outFreeLevel;
            `DIOFLX_FN_OUT_NO_FAULT: outVal = noFault;
            `DIOFLX_FN_OUT_READY: outVal = driveReady;
            default: isOut = 1'b0;
        endcase
    end

    always_ff @(posedge mclk) begin
        if (!rst_b) begin
            pinOut <= 1'b0;
            pinOe <= 1'b0;
        end else begin
            pinOut <= outVal;
            pinOe <= isOut;
        end
    end

    // local-only inputs are gated here so nothing else needs the mode
    always_ff @(posedge mclk) begin
        if (!rst_b) begin
            faultResetReq <= 1'b0;
            enableReq <= 1'b0;
        end else begin
            faultResetReq <= localMode && activeFunc == `DIOFLX_FN_FAULT_RESET && pinSync;
            enableReq <= localMode && activeFunc == `DIOFLX_FN_ENABLE && pinSync;
        end
    end

    assign refUsed = activeFunc == `DIOFLX_FN_REF;
    assign refLevel = pinSync;
    assign limNegUsed = activeFunc == `DIOFLX_FN_LIM_NEG;
    assign limNegLevel = pinSync;
endmodule : dioflx_line

/* sim/dioflx_switch_model.sv */
// Purpose: stand-in for the limit switch and the wiring on the three lines
// Assumes: the bench sets the switch contact levels
// Notes: a line that the block drives reads back its own level
`timescale 1ns/1ps
module dioflx_switch_model (
    input wire logic posLevel,
    input wire logic [2:0] extLevel,
    input wire logic [2:0] linePinOut,
    input wire logic [2:0] linePinOe,
    output logic posLimitPin,
    output logic [2:0] linePinIn
);
    // contact level goes straight to the pin, polarity is the block's job
    assign posLimitPin = posLevel;
    assign linePinIn = (linePinOe & linePinOut) | (~linePinOe & extLevel);
endmodule : dioflx_switch_model

/* sim/dioflx_top_chk.sv */
// Purpose: port checks of the drive i/o function block
// Assumes: one clock, sync active-low reset
// Notes: selectors stay free until power-on, so no line drives or requests
`timescale 1ns/1ps
module dioflx_top_chk (
    input wire logic mclk,
    input wire logic rst_b,
    input wire logic [11:0] parAddr,
    input wire logic [15:0] parWdata,
    input wire logic parWrite,
    input wire logic parErr,
    input wire logic powerStageOn,
    input wire logic cyclicSyncMode,
    input wire logic [2:0] linePinOe,
    input wire logic enableReq,
    input wire logic faultResetReq,
    input wire logic refSwitchHit,
    input wire logic posLimitHit,
    input wire logic limitErr
);
    default clocking @(posedge mclk); endclocking
    default disable iff (!rst_b);
    busy_refuse_a: assert property (
        parWrite && powerStageOn |=> parErr) else $error("write taken while enabled");
    two_code_a: assert property (
        parWrite && parAddr == 12'h0724 && parWdata == 16'h0009 |=> parErr)
        else $error("line two took code 9");
    three_code_a: assert property (
        parWrite && parAddr inside {12'h0726, 12'h0728} && parWdata == 16'h0016 |=> parErr)
        else $error("line three or four took code 22");
    ref_zero_a: assert property (
        parWrite && parAddr == 12'h061c && parWdata == 16'h0000 |=> parErr)
        else $error("reference evaluation took 0");
    pol_range_a: assert property (
        parWrite && parAddr inside {12'h061e, 12'h0620} && parWdata > 16'h0002 |=> parErr)
        else $error("limit evaluation took a code above 2");
    rel_range_a: assert property (
        parWrite && parAddr == 12'h060c && parWdata > 16'h0002 |=> parErr)
        else $error("release mode took a code above 2");
    no_output_a: assert property (
        linePinOe == 3'b000) else $error("line driven before power-on");
    idle_lines_a: assert property (
        !enableReq && !faultResetReq && !refSwitchHit) else $error("free line acted");
    err_hold_a: assert property (
        limitErr && !cyclicSyncMode |=> limitErr) else $error("limit error cleared off mode");
    err_set_a: assert property (
        !cyclicSyncMode && !$past(cyclicSyncMode) && powerStageOn && $past(powerStageOn)
        && $past(powerStageOn, 2) && posLimitHit |=> limitErr)
        else $error("limit hit did not raise error");
endmodule : dioflx_top_chk

bind dioflx_top dioflx_top_chk dioflx_top_chk_i (.mclk(mclk), .rst_b(rst_b),
    .parAddr(parAddr), .parWdata(parWdata), .parWrite(parWrite), .parErr(parErr),
    .powerStageOn(powerStageOn), .cyclicSyncMode(cyclicSyncMode), .linePinOe(linePinOe),
    .enableReq(enableReq), .faultResetReq(faultResetReq), .refSwitchHit(refSwitchHit),
    .posLimitHit(posLimitHit), .limitErr(limitErr));

/* sim/dioflx_top_bench.sv */
// Purpose: self-checking bench for the drive i/o function block
// Assumes: inputs change on the falling edge, strobes are one-cycle pulses
// Notes: selectors only go active at power-on, so line codes are checked by readback
`timescale 1ns/1ps
`define CHK(n, e, g) begin checks++; if ((g) !== (e)) begin errorCnt++; \
    $display("Error %s exp %h got %h", n, e, g); end end
module dioflx_top_bench;
    import dioflx_pkg::*;
    logic mclk, rst_b, parWrite, parRead, parAck, parErr, powerStageOn, localMode;
    logic cyclicSyncMode, refMoveActive, noFault, driveReady, posLimitPin, limitErrClear;
    logic faultResetReq, enableReq, negLimitHit, posLimitHit, refSwitchHit, limitErr, posLevel;
    logic [11:0] parAddr;
    dioflx_word_t parWdata, parRdata;
    logic [2:0] outFreeLevel, linePinIn, linePinOut, linePinOe, extLevel;
    int errorCnt = 0;
    int checks = 0;
    dioflx_top dioflx_top_i (.mclk(mclk), .rst_b(rst_b), .parAddr(parAddr),
        .parWdata(parWdata), .parWrite(parWrite), .parRead(parRead), .parRdata(parRdata),
        .parAck(parAck), .parErr(parErr), .powerStageOn(powerStageOn), .localMode(localMode),
        .cyclicSyncMode(cyclicSyncMode), .refMoveActive(refMoveActive), .noFault(noFault),
        .driveReady(driveReady), .outFreeLevel(outFreeLevel), .linePinIn(linePinIn),
        .linePinOut(linePinOut), .linePinOe(linePinOe), .posLimitPin(posLimitPin),
        .limitErrClear(limitErrClear), .faultResetReq(faultResetReq), .enableReq(enableReq),
        .negLimitHit(negLimitHit), .posLimitHit(posLimitHit), .refSwitchHit(refSwitchHit),
        .limitErr(limitErr));
    dioflx_switch_model dioflx_switch_model_i (.posLevel(posLevel), .extLevel(extLevel),
        .linePinOut(linePinOut), .linePinOe(linePinOe), .posLimitPin(posLimitPin),
        .linePinIn(linePinIn));

    task automatic tick(input int n);
        repeat (n) @(negedge mclk);
    endtask : tick

    // one strobe, answer checked one cycle later while it stands
    task automatic xfer(input logic wr, input logic [11:0] a, input dioflx_word_t d,
            input logic e, input dioflx_word_t q);
        @(negedge mclk);
        parAddr = a;
        parWdata = d;
        parWrite = wr;
        parRead = !wr;
        @(negedge mclk);
        parWrite = 1'b0;
        parRead = 1'b0;
        `CHK("ack", 1'b1, parAck)
        `CHK("err", e, parErr)
        if (!wr && !e) `CHK("rdata", q, parRdata)
    endtask : xfer

    task automatic t_reset_values;
        for (int i = 0; i < 3; i++) begin
            xfer(1'b0, 12'h0724 + 12'(2 * i), 16'h0000, 1'b0, 16'h0001);
            xfer(1'b0, 12'h061c + 12'(2 * i), 16'h0000, 1'b0, 16'h0001);
        end
        xfer(1'b0, 12'h060c, 16'h0000, 1'b0, 16'h0000);
    endtask : t_reset_values

    task automatic t_line_codes;
        dioflx_word_t codes [14] = '{16'h0000, 16'h0001, 16'h0002, 16'h0003, 16'h0004,
            16'h0005, 16'h0009, 16'h000a, 16'h000b, 16'h0014, 16'h0016, 16'h0065,
            16'h0066, 16'h0067};
        logic e;
        dioflx_word_t last;
        for (int j = 0; j < 3; j++) begin
            last = 16'h0001;
            foreach (codes[k]) begin
                e = codes[k] inside {16'h0000, 16'h0005} || (j == 0 && codes[k] == 16'h0009)
                    || (j != 0 && codes[k] == 16'h0016);
                xfer(1'b1, 12'h0724 + 12'(2 * j), codes[k], e, 16'h0000);
                if (!e) last = codes[k];
                xfer(1'b0, 12'h0724 + 12'(2 * j), 16'h0000, 1'b0, last);
                `CHK("oe", 3'b000, linePinOe)
            end
        end
    endtask : t_line_codes

    // while enabled every write is refused and the stored value kept
    task automatic t_power_refuse;
        powerStageOn = 1'b1;
        xfer(1'b1, 12'h0724, 16'h0001, 1'b1, 16'h0000);
        xfer(1'b1, 12'h0620, 16'h0002, 1'b1, 16'h0000);
        xfer(1'b0, 12'h0620, 16'h0000, 1'b0, 16'h0001);
        xfer(1'b0, 12'h0000, 16'h0000, 1'b1, 16'h0000);
        powerStageOn = 1'b0;
    endtask : t_power_refuse

    task automatic t_eval_codes;
        logic [11:0] a;
        for (int j = 0; j < 4; j++) begin
            a = (j == 0) ? 12'h060c : 12'h061c + 12'(2 * (j - 1));
            for (int c = 0; c < 4; c++)
                xfer(1'b1, a, 16'(c), c == 3 || (j == 1 && c == 0), 16'h0000);
            xfer(1'b0, a, 16'h0000, 1'b0, 16'h0002);
        end
    endtask : t_eval_codes

    // stored settings wait for the next enable; the error clears only in cyclic mode
    task automatic t_pos_limit;
        xfer(1'b1, 12'h060c, 16'h0001, 1'b0, 16'h0000);
        posLevel = 1'b0;
        tick(4);
        `CHK("hit nc open", 1'b1, posLimitHit)
        posLevel = 1'b1;
        tick(4);
        `CHK("hit nc closed", 1'b0, posLimitHit)
        powerStageOn = 1'b1;
        tick(5);
        `CHK("hit no closed", 1'b1, posLimitHit)
        `CHK("err set", 1'b1, limitErr)
        posLevel = 1'b0;
        limitErrClear = 1'b1;
        tick(4);
        `CHK("err kept", 1'b1, limitErr)
        cyclicSyncMode = 1'b1;
        tick(2);
        `CHK("err cleared", 1'b0, limitErr)
        `CHK("neg idle", 1'b0, negLimitHit)
        `CHK("out idle", 3'b000, linePinOut)
        limitErrClear = 1'b0;
        cyclicSyncMode = 1'b0;
        powerStageOn = 1'b0;
    endtask : t_pos_limit

    // mode 2: a switch already hit at enable raises no error until hit anew
    task automatic t_mode_two;
        xfer(1'b1, 12'h060c, 16'h0002, 1'b0, 16'h0000);
        posLevel = 1'b1;
        tick(4);
        cyclicSyncMode = 1'b1;
        powerStageOn = 1'b1;
        tick(6);
        `CHK("m2 hit", 1'b1, posLimitHit)
        `CHK("m2 masked", 1'b0, limitErr)
        posLevel = 1'b0;
        tick(4);
        posLevel = 1'b1;
        tick(4);
        `CHK("m2 new hit", 1'b1, limitErr)
        posLevel = 1'b0;
        limitErrClear = 1'b1;
        tick(4);
        `CHK("m2 cleared", 1'b0, limitErr)
        limitErrClear = 1'b0;
        cyclicSyncMode = 1'b0;
        powerStageOn = 1'b0;
    endtask : t_mode_two

    task automatic giveVerdict;
        $display("checks %0d errors %0d", checks, errorCnt);
        if (errorCnt == 0 && checks > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask : giveVerdict

    initial begin
        mclk = 1'b0;
        forever #20 mclk = ~mclk;
    end

    initial begin
        {rst_b, parWrite, parRead, powerStageOn, cyclicSyncMode, limitErrClear} = '0;
        {localMode, refMoveActive, noFault, driveReady, posLevel} = '1;
        parAddr = 12'h0000;
        parWdata = 16'h0000;
        outFreeLevel = 3'b101;
        extLevel = 3'b010;
        tick(4);
        rst_b = 1'b1;
        t_reset_values();
        t_line_codes();
        t_power_refuse();
        t_eval_codes();
        t_pos_limit();
        t_mode_two();
        giveVerdict();
    end

    initial begin
        #400000;
        errorCnt++;
        giveVerdict();
    end
endmodule : dioflx_top_bench
